// file: hw/uhf_defines.svh
// Timing and framing constants for the serial flow-control block
`ifndef UHF_DEFINES_SVH
`define UHF_DEFINES_SVH
`define UHF_CLK_HZ 40000000
`define UHF_BAUD_DIV 16'h0015
`define UHF_DATA_BITS 8
`define UHF_FIFO_DEPTH 8
`define UHF_SYNC_RESET 2'h3
`endif

// file: hw/uhf_pkg.sv
// Types shared by the serial flow-control block
package uhf_pkg;
  typedef enum logic [1:0] {
    UHF_TX_IDLE,
    UHF_TX_START,
    UHF_TX_DATA,
    UHF_TX_STOP
  } uhf_tx_state_type;
  typedef enum logic [1:0] {
    UHF_RX_IDLE,
    UHF_RX_START,
    UHF_RX_DATA,
    UHF_RX_STOP
  } uhf_rx_state_type;
endpackage : uhf_pkg

// file: hw/uhf_fifo.sv
// Parameterised valid/ready FIFO for transmit data
`timescale 1ns/1ps
module uhf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic in_ready_ff;
  logic push;
  logic pop;
  // Registered so the ready output comes straight from a flop
  assign in_ready = in_ready_ff;
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
      in_ready_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != (AW+1)'(DEPTH));
    end
  end
endmodule : uhf_fifo

// file: hw/uhf_port.sv
// One asynchronous serial port with hardware handshake lines
//
// Behaviour
// R1: Handshake lines act only while flow control is enabled for the port.
// R2: With clear-to-send asserted and data ready, a frame starts.
// R3: With clear-to-send deasserted, pending data is held, no frame starts.
// R4: Clear-to-send is sampled only at frame start, not mid-frame.
// R5: Ready-to-receive is high while the receive register holds no unread data.
// R6: The fast port uses the same handshake with its own lines.
// R7: The fast port has its own serial input and output pins.
// R8: The partner drives clear-to-send high when it can take a frame.
// R9: Clear-to-send is synchronised to the clock before use.
`timescale 1ns/1ps
`include "uhf_defines.svh"
module uhf_port #(
  parameter int DATA_BITS = `UHF_DATA_BITS,
  parameter int FIFO_DEPTH = `UHF_FIFO_DEPTH,
  parameter logic [15:0] BAUD_DIV = `UHF_BAUD_DIV
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flow_enable,
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_read,
  input wire logic clear_to_send_in,
  output logic ready_to_receive_out,
  input wire logic serial_in,
  output logic serial_out
);
  import uhf_pkg::*;
  localparam int BW = $clog2(DATA_BITS);
  logic [DATA_BITS-1:0] q_data;
  logic q_valid;
  logic q_pop;
  logic cts_meta_ff;
  logic cts_sync_ff;
  logic [1:0] rxs_ff;
  uhf_tx_state_type tx_st_ff;
  logic [15:0] tx_baud_ff;
  logic [BW-1:0] tx_bit_ff;
  logic [DATA_BITS-1:0] tx_shift_ff;
  uhf_rx_state_type rx_st_ff;
  logic [15:0] rx_baud_ff;
  logic [BW-1:0] rx_bit_ff;
  logic [DATA_BITS-1:0] rx_shift_ff;
  logic tx_tick;
  logic rx_tick;
  logic may_start;
  logic rx_in;
  logic rx_done;
  logic nxt_rx_valid;

  uhf_fifo #(
    .WIDTH(DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );

  // R9 R6 two-stage sync
  always_ff @(posedge clk) begin
    if (rst) begin
      cts_meta_ff <= 1'b0;
      cts_sync_ff <= 1'b0;
    end else begin
      cts_meta_ff <= clear_to_send_in;
      cts_sync_ff <= cts_meta_ff;
    end
  end

  // R7 own serial input
  always_ff @(posedge clk) begin
    if (rst) begin
      rxs_ff <= `UHF_SYNC_RESET;
    end else begin
      rxs_ff <= {rxs_ff[0], serial_in};
    end
  end
  assign rx_in = rxs_ff[1];

  // R1 R8 gate only when enabled
  assign may_start = !flow_enable || cts_sync_ff;
  // R2 R3 R4 start check at idle only
  assign q_pop = (tx_st_ff == UHF_TX_IDLE) && q_valid && may_start;
  assign tx_tick = (tx_baud_ff == BAUD_DIV);

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_ff <= UHF_TX_IDLE;
      tx_baud_ff <= '0;
      tx_bit_ff <= '0;
      tx_shift_ff <= '0;
      serial_out <= 1'b1;
    end else begin
      tx_baud_ff <= (tx_tick || tx_st_ff == UHF_TX_IDLE) ? '0
                    : tx_baud_ff + 16'h0001;
      case (tx_st_ff)
        UHF_TX_IDLE: begin
          serial_out <= 1'b1;
          if (q_pop) begin
            tx_shift_ff <= q_data;
            serial_out <= 1'b0;
            tx_st_ff <= UHF_TX_START;
          end
        end
        UHF_TX_START: begin
          if (tx_tick) begin
            serial_out <= tx_shift_ff[0];
            tx_shift_ff <= tx_shift_ff >> 1;
            tx_bit_ff <= '0;
            tx_st_ff <= UHF_TX_DATA;
          end
        end
        UHF_TX_DATA: begin
          if (tx_tick) begin
            if (tx_bit_ff == BW'(DATA_BITS-1)) begin
              serial_out <= 1'b1;
              tx_st_ff <= UHF_TX_STOP;
            end else begin
              serial_out <= tx_shift_ff[0];
              tx_shift_ff <= tx_shift_ff >> 1;
              tx_bit_ff <= tx_bit_ff + 1'b1;
            end
          end
        end
        UHF_TX_STOP: begin
          if (tx_tick) begin
            tx_st_ff <= UHF_TX_IDLE;
          end
        end
        default: tx_st_ff <= UHF_TX_IDLE;
      endcase
    end
  end

  assign rx_tick = (rx_baud_ff == BAUD_DIV);
  assign rx_done = (rx_st_ff == UHF_RX_STOP) && rx_tick && rx_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_st_ff <= UHF_RX_IDLE;
      rx_baud_ff <= '0;
      rx_bit_ff <= '0;
      rx_shift_ff <= '0;
    end else begin
      rx_baud_ff <= (rx_tick || rx_st_ff == UHF_RX_IDLE) ? '0
                    : rx_baud_ff + 16'h0001;
      case (rx_st_ff)
        UHF_RX_IDLE: begin
          if (!rx_in) begin
            rx_st_ff <= UHF_RX_START;
            rx_baud_ff <= {1'b0, BAUD_DIV[15:1]};
          end
        end
        UHF_RX_START: begin
          if (rx_tick) begin
            rx_bit_ff <= '0;
            rx_st_ff <= rx_in ? UHF_RX_IDLE : UHF_RX_DATA;
          end
        end
        UHF_RX_DATA: begin
          if (rx_tick) begin
            rx_shift_ff <= {rx_in, rx_shift_ff[DATA_BITS-1:1]};
            if (rx_bit_ff == BW'(DATA_BITS-1)) begin
              rx_st_ff <= UHF_RX_STOP;
            end else begin
              rx_bit_ff <= rx_bit_ff + 1'b1;
            end
          end
        end
        UHF_RX_STOP: begin
          if (rx_tick) begin
            rx_st_ff <= UHF_RX_IDLE;
          end
        end
        default: rx_st_ff <= UHF_RX_IDLE;
      endcase
    end
  end

  // Pending-byte flag after this edge; a new frame wins over a read
  always_comb begin
    nxt_rx_valid = rx_valid;
    if (rx_done) begin
      nxt_rx_valid = 1'b1;
    end else if (rx_read) begin
      nxt_rx_valid = 1'b0;
    end
  end

  // Receive register
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data <= '0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= nxt_rx_valid;
      if (rx_done) begin
        rx_data <= rx_shift_ff;
      end
    end
  end

  // R5 R1 ready while register empty
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_to_receive_out <= 1'b0;
    end else begin
      ready_to_receive_out <= flow_enable && !nxt_rx_valid;
    end
  end
endmodule : uhf_port

// file: verif/uhf_port_chk.sv
// Handshake and frame timing checks for one serial port
`timescale 1ns/1ps
module uhf_port_chk #(
  parameter logic [15:0] BAUD_DIV = 16'h0015
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flow_enable,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic rx_read,
  input wire logic clear_to_send_in,
  input wire logic ready_to_receive_out,
  input wire logic serial_out
);
  localparam int STOP = 9 * (BAUD_DIV + 1);
  logic [15:0] hi_ff;
  logic idle;
  // Idle once the line stayed high a whole frame
  assign idle = hi_ff >= 16'(10 * (BAUD_DIV + 1));
  always_ff @(posedge clk) begin
    if (rst || !serial_out) begin
      hi_ff <= 16'h0000;
    end else if (!idle) begin
      hi_ff <= hi_ff + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_rtr_busy: assert property (
    rx_valid |-> !ready_to_receive_out) else $error("rtr busy");
  chk_rtr_free: assert property (
    flow_enable ##1 !rx_valid |-> ready_to_receive_out)
    else $error("rtr free");
  chk_rtr_off: assert property (
    !flow_enable ##1 !flow_enable |-> !ready_to_receive_out)
    else $error("rtr off");
  chk_cts_hold: assert property (
    (flow_enable && !clear_to_send_in) [*5] ##0 idle |=> serial_out)
    else $error("cts hold");
  chk_cts_go: assert property (
    (flow_enable && clear_to_send_in) [*3] ##0 idle && tx_valid && tx_ready
    |-> ##[1:4] !serial_out) else $error("cts go");
  chk_flow_off: assert property (
    !flow_enable [*3] ##0 idle && tx_valid && tx_ready
    |-> ##[1:4] !serial_out) else $error("flow off");
  chk_frame_stop: assert property (
    !serial_out && idle |-> ##STOP serial_out) else $error("frame stop");
  chk_cts_sync: assert property (
    (flow_enable && !clear_to_send_in) [*5]
    ##1 flow_enable && clear_to_send_in && idle
    |=> serial_out) else $error("cts sync");
endmodule : uhf_port_chk

// file: verif/uhf_peer.sv
// Far-end serial device: grants clear-to-send and echoes the line
`timescale 1ns/1ps
module uhf_peer (
  input wire logic clk,
  input wire logic accept,
  input wire logic line_in,
  output logic clear_to_send,
  output logic line_out
);
  // grant only while able to take frames
  assign clear_to_send = accept;
  logic echo_ff = 1'b1;
  always @(posedge clk) begin
    echo_ff <= line_in;
  end
  assign line_out = echo_ff;
endmodule : uhf_peer

// file: verif/test_uart_hardware_flow_control.sv
// Bench for two serial ports (index 0 and index 1), both built with the same BAUD_DIV of 2
`timescale 1ns/1ps
module test_uart_hardware_flow_control;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fe [2], tv [2], rr [2], go [2];
  wire tr [2], rv [2], cts [2], rtr [2], si [2], so [2];
  logic [7:0] td [2];
  wire [7:0] rd [2];
  int miscompares = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  for (genvar i = 0; i < 2; i++) begin : g
    uhf_port #(.BAUD_DIV(16'h0002)) uhf_port_i (.clk(clk), .rst(rst),
      .flow_enable(fe[i]), .tx_data(td[i]), .tx_valid(tv[i]),
      .tx_ready(tr[i]), .rx_data(rd[i]), .rx_valid(rv[i]),
      .rx_read(rr[i]), .clear_to_send_in(cts[i]),
      .ready_to_receive_out(rtr[i]), .serial_in(si[i]),
      .serial_out(so[i]));
    uhf_peer uhf_peer_i (.clk(clk), .accept(go[i]), .line_in(so[i]),
      .clear_to_send(cts[i]), .line_out(si[i]));
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic send(int p, logic [7:0] b, int n);
    tv[p] = 1'b1;
    for (int k = 0; k < n; k++) begin
      td[p] = b + 8'(k);
      check("tx_ready", 8'h01, 8'(tr[p]));
      @(negedge clk);
    end
    tv[p] = 1'b0;
  endtask : send
  task automatic get(int p, logic [7:0] exp);
    int n;
    n = 0;
    while (rv[p] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n < 200) begin
      check("rx_data", exp, rd[p]);
      check("rtr busy", 8'h00, 8'(rtr[p]));
      rr[p] = 1'b1;
      @(negedge clk);
      rr[p] = 1'b0;
    end else begin
      miscompares++;
      final_report();
    end
  endtask : get
  task automatic t_fill(int p);
    check("rtr idle", 8'h01, 8'(rtr[p]));
    go[p] = 1'b0;
    repeat (3) @(negedge clk);
    send(p, 8'ha0, 8);
    check("tx_ready full", 8'h00, 8'(tr[p]));
    repeat (40) @(negedge clk);
    check("line held", 8'h01, 8'(so[p]));
    go[p] = 1'b1;
    for (int k = 0; k < 8; k++) get(p, 8'ha0 + 8'(k));
  endtask : t_fill
  task automatic t_mid(int p);
    repeat (40) @(negedge clk);
    send(p, 8'h5a, 2);
    repeat (4) @(negedge clk);
    go[p] = 1'b0;
    get(p, 8'h5a);
    check("other line", 8'h01, 8'(so[1-p]));
    repeat (60) @(negedge clk);
    check("rx_valid held", 8'h00, 8'(rv[p]));
    go[p] = 1'b1;
    get(p, 8'h5b);
  endtask : t_mid
  task automatic t_off(int p);
    fe[p] = 1'b0;
    go[p] = 1'b0;
    repeat (40) @(negedge clk);
    check("rtr off", 8'h00, 8'(rtr[p]));
    send(p, 8'hc3, 1);
    get(p, 8'hc3);
    fe[p] = 1'b1;
    go[p] = 1'b1;
  endtask : t_off
  initial begin
    for (int p = 0; p < 2; p++) begin
      fe[p] = 1'b1;
      tv[p] = 1'b0;
      rr[p] = 1'b0;
      td[p] = 8'h00;
      go[p] = 1'b1;
    end
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (40) @(negedge clk);
    for (int p = 0; p < 2; p++) begin
      t_fill(p);
      t_mid(p);
      t_off(p);
    end
    final_report();
  end
endmodule : test_uart_hardware_flow_control
bind uhf_port uhf_port_chk #(.BAUD_DIV(BAUD_DIV)) uhf_port_chk_i (
  .clk(clk), .rst(rst), .flow_enable(flow_enable), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_read(rx_read),
  .clear_to_send_in(clear_to_send_in),
  .ready_to_receive_out(ready_to_receive_out), .serial_out(serial_out));
